// ### inc/pbg_pkg.sv
// Constants for the phone and buzzer gain control register block.

package pbg_pkg;

   // ==========================================================
   // Register indices; byte address is four times the index.
   // ==========================================================
   localparam logic [5:0] GAIN_IDX = 6'h1f; // Gain register.
   localparam logic [5:0] CTRL_IDX = 6'h30; // Soft-step and AGC control.
   localparam logic [5:0] ISTAT_IDX = 6'h31; // Interrupt status.
   localparam logic [5:0] IMASK_IDX = 6'h32; // Interrupt mask.

   // ==========================================================
   // Gain register fields.
   // ==========================================================
   localparam int PH_PD_BIT = 15; // Phone stage powerdown.
   localparam int PH_CODE_LSB = 8; // Phone gain code low bit.
   localparam int PH_FLAG_BIT = 7; // Phone settled or saturated flag.
   localparam int BZ_PD_BIT = 6; // Buzzer stage powerdown.
   localparam int BZ_CODE_LSB = 2; // Buzzer gain code low bit.
   localparam int BZ_FLAG_BIT = 1; // Buzzer settled flag.
   localparam int PH_CODE_W = 7; // Phone code width.
   localparam int BZ_CODE_W = 4; // Buzzer code width.

   // ==========================================================
   // Reset values and code limits.
   // ==========================================================
   localparam logic PD_RST = 1'b1; // Both stages start powered down.
   localparam logic [6:0] PH_CODE_RST = 7'h45; // Phone 0 dB.
   localparam logic [6:0] PH_CODE_MIN = 7'h00; // Phone -34.5 dB.
   localparam logic [6:0] PH_CODE_MAX = 7'h5d; // Phone 12 dB ceiling.
   localparam logic [3:0] BZ_CODE_RST = 4'hf; // Buzzer 0 dB.

   // ==========================================================
   // Control and interrupt bit positions.
   // ==========================================================
   localparam int CTRL_PH_SSD = 0; // Phone soft-step disable.
   localparam int CTRL_BZ_SSD = 1; // Buzzer soft-step disable.
   localparam int CTRL_AGC_EN = 2; // AGC drives the phone stage.
   localparam int IRQ_PH_SET = 0; // Phone gain settled.
   localparam int IRQ_BZ_SET = 1; // Buzzer gain settled.
   localparam int IRQ_AGC_SAT = 2; // AGC reached saturation.
   localparam int IRQ_W = 3; // Number of events.

   // ==========================================================
   // AXI4-Lite responses.
   // ==========================================================
   localparam logic [1:0] RESP_OKAY = 2'h0; // Accepted.
   localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address.

endpackage : pbg_pkg

// ### core/pbg_softstep.sv
// Soft-stepping gain stage that walks an applied code to its target.
`timescale 1ns/1ps
`default_nettype none

module pbg_softstep #(
   parameter int W = 4, // Code width.
   parameter logic [W-1:0] RST_CODE = '0 // Applied code after reset.
) (
   input wire logic clk, // Device clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic step_tick, // One pulse per reference sample.
   input wire logic step_off, // Soft-step disable.
   input wire logic [W-1:0] target, // Programmed code.
   output logic [W-1:0] applied // Code applied to the stage.
);

   // ==========================================================
   // Stepping.
   // ==========================================================
   // One code per tick toward the target, or a jump when disabled.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         applied <= RST_CODE;
      end
      else if (step_off)
      begin
         applied <= target;
      end
      else if (step_tick && (applied < target))
      begin
         applied <= applied + W'(1);
      end
      else if (step_tick && (applied > target))
      begin
         applied <= applied - W'(1);
      end
   end

endmodule : pbg_softstep

`default_nettype wire

// ### core/pbg_gain_ctrl.sv
// Phone and buzzer gain control register with AXI4-Lite access.
`timescale 1ns/1ps
`default_nettype none

module pbg_gain_ctrl (
   input wire logic clk, // Device clock, 40 MHz.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic s_axi_awvalid, // Address valid.
   output logic s_axi_awready, // Address ready.
   input wire logic [7:0] s_axi_awaddr, // Byte address.
   input wire logic s_axi_wvalid, // Data valid.
   output logic s_axi_wready, // Data ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Byte enables.
   output logic s_axi_bvalid, // Response valid.
   input wire logic s_axi_bready, // Response ready.
   output logic [1:0] s_axi_bresp, // Response code.
   input wire logic s_axi_arvalid, // Address valid.
   output logic s_axi_arready, // Address ready.
   input wire logic [7:0] s_axi_araddr, // Byte address.
   output logic s_axi_rvalid, // Data valid.
   input wire logic s_axi_rready, // Data ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Response code.
   input wire logic fs_tick, // Reference sample pulse.
   input wire logic [6:0] agc_gain, // Gain chosen by the AGC loop.
   output logic phone_stage_powerdown, // Phone stage off.
   output logic [6:0] phone_gain_applied, // Phone gain in use.
   output logic buzzer_stage_powerdown, // Buzzer stage off.
   output logic [3:0] buzzer_gain_applied, // Buzzer gain in use.
   output logic irq // Level interrupt.
);

   // ==========================================================
   // Declarations.
   // ==========================================================
   logic [6:0] phone_gain_code_reg; // Programmed phone code.
   logic [3:0] buzzer_gain_code_reg; // Programmed buzzer code.
   logic [2:0] ctrl_reg; // Soft-step disables and AGC enable.
   logic [2:0] istat_reg; // Sticky event bits.
   logic [2:0] imask_reg; // Event enables.
   logic phone_gain_settled_flag; // Phone flag, bit 7.
   logic buzzer_gain_settled_flag; // Buzzer flag, bit 1.
   logic ph_flag_prev_reg; // Phone flag one cycle ago.
   logic bz_flag_prev_reg; // Buzzer flag one cycle ago.
   logic [7:0] aw_addr_reg; // Held write address.
   logic [31:0] w_data_reg; // Held write data.
   logic [3:0] w_strb_reg; // Held byte enables.
   logic wr_go; // Both halves of a write are held.
   logic [5:0] wr_idx; // Word index of the write.
   logic [5:0] rd_idx; // Word index of the read.
   logic [6:0] ph_target; // Phone target, clamped to the ceiling.
   logic [6:0] ph_step; // Phone code from the stepper.
   logic [3:0] bz_step; // Buzzer code from the stepper.
   logic agc_on; // AGC owns the phone stage.
   logic [2:0] ev; // Events of this cycle.
   logic [2:0] clr; // Status bits written with one.
   logic [15:0] gain_rd; // Read view of the gain register.
   logic [31:0] rd_next; // Read data for the current index.
   logic rd_hit; // Read index is mapped.

   assign agc_on = ctrl_reg[pbg_pkg::CTRL_AGC_EN];
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_idx = aw_addr_reg[7:2];
   assign rd_idx = s_axi_araddr[7:2];

   // ==========================================================
   // Write channels.
   // ==========================================================
   // Address and data are taken in either order and held.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_axi_awready <= 1'b1;
         aw_addr_reg <= 8'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         s_axi_awready <= 1'b0;
         aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_go)
      begin
         s_axi_awready <= 1'b1;
      end
   end

   // Data capture mirrors the address capture.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_axi_wready <= 1'b1;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         s_axi_wready <= 1'b0;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_go)
      begin
         s_axi_wready <= 1'b1;
      end
   end

   // The response follows the write and stands until taken.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pbg_pkg::RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         // Unmapped indices answer with an error.
         if ((wr_idx == pbg_pkg::GAIN_IDX) || (wr_idx == pbg_pkg::CTRL_IDX)
             || (wr_idx == pbg_pkg::ISTAT_IDX) || (wr_idx == pbg_pkg::IMASK_IDX))
         begin
            s_axi_bresp <= pbg_pkg::RESP_OKAY;
         end
         else
         begin
            s_axi_bresp <= pbg_pkg::RESP_SLVERR;
         end
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Gain register fields.
   // ==========================================================
   // Power-down bits sit in the high and low byte lanes.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         phone_stage_powerdown <= pbg_pkg::PD_RST;
         buzzer_stage_powerdown <= pbg_pkg::PD_RST;
      end
      else if (wr_go && (wr_idx == pbg_pkg::GAIN_IDX))
      begin
         if (w_strb_reg[1])
         begin
            phone_stage_powerdown <= w_data_reg[pbg_pkg::PH_PD_BIT];
         end
         if (w_strb_reg[0])
         begin
            buzzer_stage_powerdown <= w_data_reg[pbg_pkg::BZ_PD_BIT];
         end
      end
   end

   // Gain codes; the phone code is frozen while AGC runs.
   // Flag bits and bit 0 have no storage, so writes to them vanish.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         phone_gain_code_reg <= pbg_pkg::PH_CODE_RST;
         buzzer_gain_code_reg <= pbg_pkg::BZ_CODE_RST;
      end
      else if (wr_go && (wr_idx == pbg_pkg::GAIN_IDX))
      begin
         if (w_strb_reg[1] && !agc_on)
         begin
            phone_gain_code_reg <= w_data_reg[pbg_pkg::PH_CODE_LSB +: 7];
         end
         if (w_strb_reg[0])
         begin
            buzzer_gain_code_reg <= w_data_reg[pbg_pkg::BZ_CODE_LSB +: 4];
         end
      end
   end

   // ==========================================================
   // Own control, status and mask registers.
   // ==========================================================
   // Control bits live in the low byte lane.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_reg <= 3'h0;
      end
      else if (wr_go && (wr_idx == pbg_pkg::CTRL_IDX) && w_strb_reg[0])
      begin
         ctrl_reg <= w_data_reg[2:0];
      end
   end

   // Mask register, laid out like status.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         imask_reg <= 3'h0;
      end
      else if (wr_go && (wr_idx == pbg_pkg::IMASK_IDX) && w_strb_reg[0])
      begin
         imask_reg <= w_data_reg[2:0];
      end
   end

   // Write-one-to-clear mask for the status bits.
   assign clr = (wr_go && (wr_idx == pbg_pkg::ISTAT_IDX) && w_strb_reg[0])
                ? w_data_reg[2:0] : 3'h0;

   // Events are rising edges of the flags, split by AGC mode.
   assign ev[pbg_pkg::IRQ_PH_SET] = phone_gain_settled_flag && !ph_flag_prev_reg && !agc_on;
   assign ev[pbg_pkg::IRQ_BZ_SET] = buzzer_gain_settled_flag && !bz_flag_prev_reg;
   assign ev[pbg_pkg::IRQ_AGC_SAT] = phone_gain_settled_flag && !ph_flag_prev_reg && agc_on;

   // Sticky status; a new event wins over a clear.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         istat_reg <= 3'h0;
         ph_flag_prev_reg <= 1'b0;
         bz_flag_prev_reg <= 1'b0;
      end
      else
      begin
         istat_reg <= (istat_reg & ~clr) | ev;
         ph_flag_prev_reg <= phone_gain_settled_flag;
         bz_flag_prev_reg <= buzzer_gain_settled_flag;
      end
   end

   // Interrupt line is high while any unmasked bit is set.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(((istat_reg & ~clr) | ev) & imask_reg);
      end
   end

   // ==========================================================
   // Soft-stepping stages.
   // ==========================================================
   // Codes above the ceiling all mean 12 dB, so step to the ceiling.
   assign ph_target = (phone_gain_code_reg > pbg_pkg::PH_CODE_MAX)
                      ? pbg_pkg::PH_CODE_MAX : phone_gain_code_reg;

   // Phone stage walks half a decibel per code.
   pbg_softstep #(
      .W(7),
      .RST_CODE(pbg_pkg::PH_CODE_RST)
   ) u_phone_step (
      .clk(clk),
      .srst(srst),
      .step_tick(fs_tick),
      .step_off(ctrl_reg[pbg_pkg::CTRL_PH_SSD]),
      .target(ph_target),
      .applied(ph_step)
   );

   // Buzzer stage walks three decibels per code.
   pbg_softstep #(
      .W(4),
      .RST_CODE(pbg_pkg::BZ_CODE_RST)
   ) u_buzzer_step (
      .clk(clk),
      .srst(srst),
      .step_tick(fs_tick),
      .step_off(ctrl_reg[pbg_pkg::CTRL_BZ_SSD]),
      .target(buzzer_gain_code_reg),
      .applied(bz_step)
   );

   // Applied gains and flags, registered for clean outputs.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         phone_gain_applied <= pbg_pkg::PH_CODE_RST;
         buzzer_gain_applied <= pbg_pkg::BZ_CODE_RST;
         phone_gain_settled_flag <= 1'b0;
         buzzer_gain_settled_flag <= 1'b0;
      end
      else
      begin
         // AGC takes over the phone gain when enabled.
         phone_gain_applied <= agc_on ? agc_gain : ph_step;
         buzzer_gain_applied <= bz_step;
         if (agc_on)
         begin
            // Saturation at either end of the range.
            phone_gain_settled_flag <= (agc_gain == pbg_pkg::PH_CODE_MIN)
                                       || (agc_gain >= pbg_pkg::PH_CODE_MAX);
         end
         else
         begin
            phone_gain_settled_flag <= (ph_step == ph_target);
         end
         buzzer_gain_settled_flag <= (bz_step == buzzer_gain_code_reg);
      end
   end

   // ==========================================================
   // Read channel.
   // ==========================================================
   // Gain register image; bit 0 always reads zero.
   assign gain_rd = {phone_stage_powerdown,
                     agc_on ? phone_gain_applied : phone_gain_code_reg,
                     phone_gain_settled_flag,
                     buzzer_stage_powerdown,
                     buzzer_gain_code_reg,
                     buzzer_gain_settled_flag,
                     1'b0};

   // Read multiplexer by word index.
   always_comb
   begin
      rd_next = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (rd_idx)
         pbg_pkg::GAIN_IDX: rd_next = {16'h0000, gain_rd};
         pbg_pkg::CTRL_IDX: rd_next = {29'h0000_0000, ctrl_reg};
         pbg_pkg::ISTAT_IDX: rd_next = {29'h0000_0000, istat_reg};
         pbg_pkg::IMASK_IDX: rd_next = {29'h0000_0000, imask_reg};
         default: rd_hit = 1'b0;
      endcase
   end

   // One read at a time, answered the cycle after it is taken.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= pbg_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_next;
         s_axi_rresp <= rd_hit ? pbg_pkg::RESP_OKAY : pbg_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : pbg_gain_ctrl

`default_nettype wire

// ### tb/pbg_gain_ctrl_chk.sv
// Port-level assertions for the gain register block.
`timescale 1ns/1ps
`default_nettype none

module pbg_gain_ctrl_chk (
   input wire logic clk, // Device clock.
   input wire logic srst, // Synchronous reset.
   input wire logic s_axi_awvalid, // Write address valid.
   input wire logic s_axi_awready, // Write address ready.
   input wire logic [7:0] s_axi_awaddr, // Write byte address.
   input wire logic s_axi_wvalid, // Write data valid.
   input wire logic s_axi_wready, // Write data ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic s_axi_arvalid, // Read address valid.
   input wire logic s_axi_arready, // Read address ready.
   input wire logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic fs_tick, // Reference sample pulse.
   input wire logic [6:0] agc_gain, // Gain chosen by the loop.
   input wire logic phone_stage_powerdown, // Phone stage off.
   input wire logic [6:0] phone_gain_applied, // Phone gain in use.
   input wire logic buzzer_stage_powerdown, // Buzzer stage off.
   input wire logic [3:0] buzzer_gain_applied, // Buzzer gain in use.
   input wire logic irq // Level interrupt.
);
   // ==========================================================
   // Shadow of the control register.
   // ==========================================================
   logic [2:0] ctrl_reg; // Last control value written.
   logic [1:0] quiet_reg; // Cycles since reset or a control write.

   // Checks wait a few cycles after reset or a mode change.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_reg <= 3'h0;
         quiet_reg <= 2'h0;
      end
      else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
               && s_axi_awaddr == 8'hc0)
      begin
         ctrl_reg <= s_axi_wdata[2:0];
         quiet_reg <= 2'h0;
      end
      else if (quiet_reg != 2'h3)
      begin
         quiet_reg <= quiet_reg + 2'h1;
      end
   end

   // ==========================================================
   // Assertions.
   // ==========================================================
   property p_pd_rst;
      @(posedge clk) srst |=> phone_stage_powerdown && buzzer_stage_powerdown;
   endproperty
   a_pd_rst: assert property (p_pd_rst)
      else $error("Powerdown not set by reset.");

   property p_code_rst;
      @(posedge clk) srst |=> phone_gain_applied == 7'h45 && buzzer_gain_applied == 4'hf;
   endproperty
   a_code_rst: assert property (p_code_rst)
      else $error("Gains not at reset codes.");

   property p_ph_step;
      @(posedge clk) disable iff (srst)
      quiet_reg == 2'h3 && !ctrl_reg[0] && !ctrl_reg[2] && $changed(phone_gain_applied)
      |-> ($past(fs_tick) || $past(fs_tick, 2))
      && (phone_gain_applied == $past(phone_gain_applied) + 7'h01
      || phone_gain_applied == $past(phone_gain_applied) - 7'h01);
   endproperty
   a_ph_step: assert property (p_ph_step)
      else $error("Phone gain step is wrong.");

   property p_bz_step;
      @(posedge clk) disable iff (srst)
      quiet_reg == 2'h3 && !ctrl_reg[1] && $changed(buzzer_gain_applied)
      |-> ($past(fs_tick) || $past(fs_tick, 2))
      && (buzzer_gain_applied == $past(buzzer_gain_applied) + 4'h1
      || buzzer_gain_applied == $past(buzzer_gain_applied) - 4'h1);
   endproperty
   a_bz_step: assert property (p_bz_step)
      else $error("Buzzer gain step is wrong.");

   property p_agc;
      @(posedge clk) disable iff (srst)
      quiet_reg == 2'h3 && ctrl_reg[2] |-> phone_gain_applied == $past(agc_gain);
   endproperty
   a_agc: assert property (p_agc)
      else $error("Phone gain ignores loop gain.");

   property p_irq_rst;
      @(posedge clk) disable iff (srst) $fell(srst) |-> (!irq) [*4];
   endproperty
   a_irq_rst: assert property (p_irq_rst)
      else $error("Interrupt high after reset.");

   property p_w_ans;
      @(posedge clk) disable iff (srst)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
   endproperty
   a_w_ans: assert property (p_w_ans)
      else $error("No write response.");

   property p_r_ans;
      @(posedge clk) disable iff (srst) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_ans: assert property (p_r_ans)
      else $error("No read data.");

   property p_b_done;
      @(posedge clk) disable iff (srst) s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_done: assert property (p_b_done)
      else $error("Write response held.");
endmodule : pbg_gain_ctrl_chk

bind pbg_gain_ctrl pbg_gain_ctrl_chk u_chk (.clk(clk), .srst(srst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .fs_tick(fs_tick), .agc_gain(agc_gain), .phone_stage_powerdown(phone_stage_powerdown),
   .phone_gain_applied(phone_gain_applied), .buzzer_stage_powerdown(buzzer_stage_powerdown),
   .buzzer_gain_applied(buzzer_gain_applied), .irq(irq));

`default_nettype wire

// ### tb/test_pbg_gain_ctrl.sv
// Self-checking bench for the gain register block.
`timescale 1ns/1ps
`default_nettype none

module test_pbg_gain_ctrl;
   // ==========================================================
   // Stimulus signals and the design.
   // ==========================================================
   logic clk = 1'b0; // Device clock, 25 ns period.
   logic srst = 1'b1; // Reset held from time zero.
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, tick = 1'b0; // Strobes.
   logic [7:0] awa = 8'h00, ara = 8'h00; // Byte addresses.
   logic [31:0] wd = 32'h0; // Write data.
   logic [3:0] ws = 4'h0; // Byte enables.
   logic [6:0] agc = 7'h00; // Loop gain input.
   logic awr, wr_rdy, bv, arr, rv, ph_pd, bz_pd, irq; // Design outputs.
   logic [1:0] bresp, rresp; // Response codes.
   logic [31:0] rdata; // Read data.
   logic [6:0] ph_g; // Applied phone gain.
   logic [3:0] bz_g; // Applied buzzer gain.
   int failures = 0; // Mismatch count.
   int checks_done = 0; // Comparison count.
   typedef struct packed {logic [15:0] wd; logic [1:0] st; logic [15:0] rd; logic [6:0] ph;
      logic [3:0] bz;} pbg_row_t; // Write, strobes, read-back and applied gains.
   pbg_row_t rows [5] = '{'{16'h0000, 2'h3, 16'h0082, 7'h00, 4'h0},
      '{16'hdd83, 2'h3, 16'hdd82, 7'h5d, 4'h0}, '{16'h7f7f, 2'h3, 16'h7ffe, 7'h5d, 4'hf},
      '{16'h0004, 2'h1, 16'h7f86, 7'h5d, 4'h1}, '{16'h4500, 2'h2, 16'h4586, 7'h45, 4'h1}};

   pbg_gain_ctrl u_dut (.clk(clk), .srst(srst), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(bresp),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
      .s_axi_rready(rre), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .fs_tick(tick),
      .agc_gain(agc), .phone_stage_powerdown(ph_pd), .phone_gain_applied(ph_g),
      .buzzer_stage_powerdown(bz_pd), .buzzer_gain_applied(bz_g), .irq(irq));

   // Clock toggles every half period.
   always #12.5 clk = ~clk;

   // ==========================================================
   // Shared tasks.
   // ==========================================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // Bus write: address and data together, each dropped once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr_rdy) wv <= 1'b0;
      end
      while ((awv && !awr) || (wv && !wr_rdy));
      do @(posedge clk); while (!bv);
      bre <= 1'b0;
      chk(32'(bresp), 32'(er), "write response");
      @(posedge clk);
   endtask : wr

   // Bus read, comparing data and response code.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rv);
      rre <= 1'b0;
      chk(rdata, e, "read data");
      chk(32'(rresp), 32'(er), "read response");
      @(posedge clk);
   endtask : rd

   // One sample pulse, then time for the step to land.
   task automatic pulse;
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      cyc(4);
   endtask : pulse

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // Watchdog cuts a hang short.
   initial
   begin
      cyc(5000);
      failures++;
      give_verdict();
   end

   // ==========================================================
   // Main sequence.
   // ==========================================================
   initial
   begin
      cyc(3);
      srst <= 1'b0;
      cyc(1);
      // Rows run with soft-stepping off, so gains apply at once.
      wr(8'hc0, 32'h3, 4'hf, 2'h0);
      foreach (rows[i])
      begin
         wr(8'h7c, {16'h0, rows[i].wd}, {2'b00, rows[i].st}, 2'h0);
         cyc(4);
         rd(8'h7c, {16'h0, rows[i].rd}, 2'h0);
         chk(32'(ph_g), 32'(rows[i].ph), "phone applied");
         chk(32'(bz_g), 32'(rows[i].bz), "buzzer applied");
         chk(32'(ph_pd), 32'(rows[i].rd[15]), "phone powerdown");
         chk(32'(bz_pd), 32'(rows[i].rd[6]), "buzzer powerdown");
      end
      $display("Table test done.");
      // Soft-stepping: both stages walk three codes on three ticks.
      wr(8'hc0, 32'h0, 4'hf, 2'h0);
      wr(8'hc4, 32'h7, 4'hf, 2'h0);
      wr(8'hc8, 32'h3, 4'hf, 2'h0);
      wr(8'h7c, 32'h4810, 4'h3, 2'h0);
      cyc(3);
      rd(8'h7c, 32'h4810, 2'h0);
      chk(32'(irq), 32'h0, "irq before settle");
      for (int k = 1; k <= 3; k++)
      begin
         pulse();
         chk(32'(ph_g), 32'h45 + k, "phone step");
         chk(32'(bz_g), 32'h1 + k, "buzzer step");
      end
      rd(8'h7c, 32'h4892, 2'h0);
      rd(8'hc4, 32'h3, 2'h0);
      chk(32'(irq), 32'h1, "irq on settle");
      wr(8'hc8, 32'h0, 4'hf, 2'h0);
      cyc(2);
      chk(32'(irq), 32'h0, "irq masked");
      wr(8'hc8, 32'h7, 4'hf, 2'h0);
      cyc(2);
      chk(32'(irq), 32'h1, "irq unmasked");
      wr(8'hc4, 32'h3, 4'hf, 2'h0);
      cyc(2);
      chk(32'(irq), 32'h0, "irq cleared");
      $display("Soft-step test done.");
      // Loop gain: code shows the loop gain, flag shows saturation.
      wr(8'hc0, 32'h4, 4'hf, 2'h0);
      cyc(3);
      rd(8'h7c, 32'h0092, 2'h0);
      agc <= 7'h30;
      cyc(3);
      chk(32'(ph_g), 32'h30, "loop gain applied");
      wr(8'h7c, 32'h1010, 4'h2, 2'h0);
      rd(8'h7c, 32'h3012, 2'h0);
      agc <= 7'h5d;
      cyc(3);
      rd(8'h7c, 32'h5d92, 2'h0);
      rd(8'hc4, 32'h4, 2'h0);
      chk(32'(irq), 32'h1, "irq on saturation");
      wr(8'hc0, 32'h0, 4'hf, 2'h0);
      cyc(3);
      rd(8'h7c, 32'h4892, 2'h0);
      $display("Loop gain test done.");
      // Unmapped place is refused on both paths.
      wr(8'h40, 32'h1, 4'hf, 2'h2);
      rd(8'h40, 32'h0, 2'h2);
      $display("Unmapped test done.");
      // Mid-run reset restores the gain, control, mask and output reset values.
      srst <= 1'b1;
      cyc(3);
      srst <= 1'b0;
      cyc(3);
      rd(8'h7c, 32'hc5fe, 2'h0);
      rd(8'hc0, 32'h0, 2'h0);
      rd(8'hc8, 32'h0, 2'h0);
      chk(32'(ph_g), 32'h45, "phone reset gain");
      chk(32'(bz_g), 32'hf, "buzzer reset gain");
      chk(32'({ph_pd, bz_pd, irq}), 32'h6, "reset outputs");
      $display("Reset test done.");
      give_verdict();
   end
endmodule : test_pbg_gain_ctrl

`default_nettype wire
